// [tofcs_pkg.sv]
// shared constants and types for the tof serial command slave
package tofcs_pkg;
    // command codes
    localparam logic [7:0] CMD_INVALID  = 8'h00;
    localparam logic [7:0] CMD_TEST     = 8'h04;
    localparam logic [7:0] CMD_INFO     = 8'h05;
    localparam logic [7:0] CMD_LOG      = 8'h06;
    localparam logic [7:0] CMD_RESET    = 8'h08;
    localparam logic [7:0] CMD_ACK      = 8'h0a;
    localparam logic [7:0] CMD_NAK      = 8'h0b;
    localparam logic [7:0] CMD_SW_VER   = 8'h0c;
    localparam logic [7:0] CMD_CHIP_VER = 8'h0d;
    localparam logic [7:0] CMD_MODULE   = 8'h0e;
    localparam logic [7:0] CMD_UID      = 8'h0f;
    localparam logic [7:0] CMD_MEAS_ONE = 8'h10;
    localparam logic [7:0] CMD_MEAS_GO  = 8'h11;
    localparam logic [7:0] CMD_MEAS_END = 8'h12;
    localparam logic [7:0] CMD_CALIB    = 8'h18;
    localparam logic [7:0] CMD_REINIT   = 8'h19;
    // special byte defaults, arbitrary values
    localparam logic [7:0] DEF_START    = 8'h02;
    localparam logic [7:0] DEF_STOP     = 8'h03;
    localparam logic [7:0] DEF_ESC      = 8'h1b;
    // echo buffer depth (bytes) and reply field sizes
    localparam int         ECHO_DEPTH   = 64;
    localparam int         REPLY_BYTES  = 4;

    // one byte with valid on a stream
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tofcs_byte_t;

    // jobs handed to the measurement / control logic outside
    typedef struct packed {
        logic meas_one;
        logic meas_start;
        logic meas_stop;
        logic calib;
        logic reinit;
        logic soft_reset;
    } tofcs_job_t;
endpackage

// [tofcs_slave.sv]
// command interpreter and byte-stuffed framing for the tof serial slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] one master, separate rx and tx streams
// [R2] slave sends log frames unprompted
// [R3] frames bounded by start and stop bytes
// [R4] special payload bytes escaped and inverted
// [R5] successful command answered with ack 0x0a
// [R6] failed command answered with nak 0x0b
// [R7] master keeps one command outstanding
// [R8] master runs its own response timeout
// [R9] log message frames carry code 0x06
// [R10] test command 0x04 echoed byte for byte
// [R11] code 0x08 pulses software reset
// [R12] code 0x0c returns software version
// [R13] code 0x0d returns chip version
// [R14] code 0x0e returns module type and version
// [R15] code 0x0f returns unique id
// [R16] code 0x05 returns combined information
// [R17] code 0x10 runs one measurement
// [R18] code 0x11 starts scheduled measurements
// [R19] code 0x12 stops after current frame
// [R20] code 0x18 runs calibration
// [R21] code 0x19 reinitialises control and sensor
// [R22] unknown or invalid code gets nak
// [R23] special byte values are parameters
module tofcs_slave
    import tofcs_pkg::*;
#(
    parameter logic [7:0] START_BYTE = tofcs_pkg::DEF_START,  // [R23]
    parameter logic [7:0] STOP_BYTE  = tofcs_pkg::DEF_STOP,
    parameter logic [7:0] ESC_BYTE   = tofcs_pkg::DEF_ESC,
    parameter logic [31:0] SW_VER    = 32'h0000_0001,  // arbitrary
    parameter logic [31:0] CHIP_VER  = 32'h0000_0001,  // arbitrary
    parameter logic [31:0] MOD_VER   = 32'h0000_0001,  // arbitrary
    parameter logic [31:0] UID       = 32'h1234_5678   // arbitrary
) (
    // clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   nrst_i,
    // received byte stream from uart receiver
    input  wire tofcs_pkg::tofcs_byte_t rx_i,
    output logic                        rx_ready_o,
    // transmitted byte stream to uart transmitter
    output tofcs_pkg::tofcs_byte_t      tx_o,
    input  wire logic                   tx_ready_i,
    // log message request, one byte payload
    input  wire logic                   log_req_i,
    input  wire logic [7:0]             log_data_i,
    output logic                        log_ack_o,
    // device control
    output tofcs_pkg::tofcs_job_t       job_o,
    input  wire logic                   job_fail_i,
    output logic                        meas_auto_o,
    input  wire logic                   frame_busy_i
);
    import tofcs_pkg::*;

    typedef enum {S_IDLE, S_BODY, S_EXEC, S_HDR, S_PAY, S_END} tofcs_state_t;

    // ------------------------------------------------------------
    // receive: unstuffing into the echo buffer
    // ------------------------------------------------------------
    logic [7:0] echo_mem [ECHO_DEPTH];
    logic [6:0] rx_len;
    logic       in_frame;
    logic       esc_seen;
    logic       overflow;
    logic       frame_done;
    tofcs_state_t state;

    wire rx_take   = rx_i.valid && rx_ready_o;
    wire is_start  = rx_i.data == START_BYTE;
    wire is_stop   = rx_i.data == STOP_BYTE;
    wire is_esc    = rx_i.data == ESC_BYTE;
    wire [7:0] rx_byte = esc_seen ? ~rx_i.data : rx_i.data;  // [R4]
    wire store     = rx_take && in_frame && !is_start && !is_stop && !(is_esc && !esc_seen);
    wire full      = rx_len == 7'(ECHO_DEPTH);

    // one command at a time; the master waits for the answer anyway
    assign rx_ready_o = (state == S_IDLE) || (state == S_BODY);  // [R1] [R7]

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            in_frame   <= 1'b0;
            esc_seen   <= 1'b0;
            rx_len     <= '0;
            overflow   <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (rx_take && is_start) begin  // [R3]
                in_frame <= 1'b1;
                esc_seen <= 1'b0;
                rx_len   <= '0;
                overflow <= 1'b0;
            end else if (rx_take && in_frame && is_stop) begin  // [R3]
                in_frame   <= 1'b0;
                frame_done <= 1'b1;
            end else if (rx_take && in_frame && is_esc && !esc_seen) begin
                esc_seen <= 1'b1;  // [R4]
            end else if (store) begin
                esc_seen <= 1'b0;
                if (full) overflow <= 1'b1;
                else rx_len <= rx_len + 7'd1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (store && !full) echo_mem[rx_len[5:0]] <= rx_byte;
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire [7:0] cmd      = echo_mem[0];
    wire is_echo        = cmd == CMD_TEST;
    wire is_get         = cmd == CMD_INFO || cmd == CMD_SW_VER || cmd == CMD_CHIP_VER
                        || cmd == CMD_MODULE || cmd == CMD_UID;
    wire is_ctrl        = cmd == CMD_RESET || cmd == CMD_MEAS_ONE || cmd == CMD_MEAS_GO
                        || cmd == CMD_MEAS_END || cmd == CMD_CALIB || cmd == CMD_REINIT;
    wire cmd_bad        = overflow || rx_len == 7'd0 || !(is_echo || is_get || is_ctrl)
                        || (is_ctrl && job_fail_i);  // [R22] [R6]
    wire [31:0] get_val = (cmd == CMD_SW_VER)   ? SW_VER :     // [R12]
                          (cmd == CMD_CHIP_VER) ? CHIP_VER :   // [R13]
                          (cmd == CMD_MODULE)   ? MOD_VER :    // [R14]
                          (cmd == CMD_UID)      ? UID :        // [R15]
                          SW_VER ^ CHIP_VER ^ MOD_VER;         // [R16]

    // ------------------------------------------------------------
    // two-entry skid buffer ahead of the transmitter
    // ------------------------------------------------------------
    logic [7:0] buf_q [2];
    logic [1:0] buf_cnt;
    logic       buf_rd;
    logic       fill_valid;
    logic [7:0] fill_data;
    wire fill_ready = buf_cnt != 2'd2;
    wire drain      = tx_ready_i && buf_cnt != 2'd0;
    wire fill       = fill_valid && fill_ready;

    assign tx_o.valid = buf_cnt != 2'd0;
    assign tx_o.data  = buf_q[buf_rd];

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            buf_cnt <= '0;
            buf_rd  <= 1'b0;
        end else begin
            buf_cnt <= buf_cnt + 2'(fill) - 2'(drain);
            if (drain) buf_rd <= ~buf_rd;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (fill) buf_q[buf_rd ^ buf_cnt[0] ^ (drain & buf_cnt[1])] <= fill_data;
    end

    // ------------------------------------------------------------
    // transmit: frame builder with stuffing
    // ------------------------------------------------------------
    logic [7:0] tx_code;
    logic [31:0] tx_word;
    logic [6:0] tx_idx;
    logic [6:0] tx_len;
    logic       tx_esc;
    logic       tx_echo;
    logic       meas_auto;
    tofcs_job_t job;

    wire [7:0] pay_raw = (tx_idx == 7'd0) ? tx_code :
                         tx_echo ? echo_mem[tx_idx[5:0]] :
                         tx_word[8*(4-int'(tx_idx[2:0])) +: 8];
    wire pay_special   = pay_raw == START_BYTE || pay_raw == STOP_BYTE || pay_raw == ESC_BYTE;
    wire pay_last      = tx_idx + 7'd1 == tx_len;
    // a stop taken in this cycle must still reach execute, so a log waits for it
    wire stop_take     = rx_take && in_frame && is_stop;
    wire log_go        = state == S_IDLE && log_req_i && !frame_done && !stop_take;

    always_comb begin
        fill_valid = 1'b0;
        fill_data  = START_BYTE;
        unique case (state)
            S_HDR: begin
                fill_valid = 1'b1;
                fill_data  = START_BYTE;  // [R3]
            end
            S_PAY: begin
                fill_valid = 1'b1;
                if (pay_special && !tx_esc) fill_data = ESC_BYTE;  // [R4]
                else if (pay_special)       fill_data = ~pay_raw;  // [R4]
                else                        fill_data = pay_raw;
            end
            S_END: begin
                fill_valid = 1'b1;
                fill_data  = STOP_BYTE;  // [R3]
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state     <= S_IDLE;
            tx_code   <= CMD_ACK;
            tx_word   <= '0;
            tx_idx    <= '0;
            tx_len    <= 7'd1;
            tx_esc    <= 1'b0;
            tx_echo   <= 1'b0;
            meas_auto <= 1'b0;
            job       <= '0;
            log_ack_o <= 1'b0;
        end else begin
            job       <= '0;
            log_ack_o <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (frame_done) begin
                        state <= S_EXEC;
                    end else if (log_go) begin  // [R2] [R9]
                        tx_code   <= CMD_LOG;
                        tx_word   <= {log_data_i, 24'h0};
                        tx_len    <= 7'd2;
                        tx_echo   <= 1'b0;
                        tx_idx    <= '0;
                        log_ack_o <= 1'b1;
                        state     <= S_HDR;
                    end else if (in_frame) begin
                        state <= S_BODY;
                    end
                end
                S_BODY: if (frame_done) state <= S_EXEC;
                S_EXEC: begin
                    tx_idx  <= '0;
                    tx_echo <= 1'b0;
                    state   <= S_HDR;
                    if (cmd_bad) begin
                        tx_code <= CMD_NAK;  // [R6] [R22]
                        tx_len  <= 7'd1;
                    end else if (is_echo) begin
                        tx_code <= CMD_TEST;  // [R10]
                        tx_echo <= 1'b1;
                        tx_len  <= rx_len;
                    end else if (is_get) begin
                        tx_code <= cmd;
                        tx_word <= get_val;
                        tx_len  <= 7'(1 + REPLY_BYTES);
                    end else begin
                        tx_code <= CMD_ACK;  // [R5]
                        tx_len  <= 7'd1;
                        job.soft_reset <= cmd == CMD_RESET;     // [R11]
                        job.meas_one   <= cmd == CMD_MEAS_ONE;  // [R17]
                        job.meas_start <= cmd == CMD_MEAS_GO;   // [R18]
                        job.meas_stop  <= cmd == CMD_MEAS_END;  // [R19]
                        job.calib      <= cmd == CMD_CALIB;     // [R20]
                        job.reinit     <= cmd == CMD_REINIT;    // [R21]
                        if (cmd == CMD_MEAS_GO) meas_auto <= 1'b1;
                        if (cmd == CMD_MEAS_END || cmd == CMD_REINIT || cmd == CMD_RESET)
                            meas_auto <= 1'b0;
                    end
                end
                S_HDR: if (fill_ready) state <= S_PAY;
                S_PAY: if (fill_ready) begin
                    if (pay_special && !tx_esc) begin
                        tx_esc <= 1'b1;
                    end else begin
                        tx_esc <= 1'b0;
                        tx_idx <= tx_idx + 7'd1;
                        if (pay_last) state <= S_END;
                    end
                end
                S_END: if (fill_ready) state <= S_IDLE;
            endcase
        end
    end

    // stop lets the running frame finish: auto flag drops, frame busy is the outside's
    assign job_o       = job;
    assign meas_auto_o = meas_auto;  // [R19]

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ack_after_ok: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R5]
        state == S_EXEC && !cmd_bad && is_ctrl |=> tx_code == CMD_ACK)
        else $error("ack not chosen for good command");
    a_nak_on_bad: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R6]
        state == S_EXEC && cmd_bad |=> tx_code == CMD_NAK && tx_len == 7'd1)
        else $error("nak not chosen for failed command");
    a_nak_unknown: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R22]
        state == S_EXEC && cmd == CMD_INVALID |=> tx_code == CMD_NAK)
        else $error("invalid code not refused");
    a_frame_opens: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R3]
        state == S_HDR |-> fill_valid && fill_data == START_BYTE)
        else $error("frame does not open with start byte");
    a_esc_pair: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R4]
        fill && state == S_PAY && fill_data == ESC_BYTE && !tx_esc
        |=> fill_data == ~pay_raw)
        else $error("escape not followed by inverted byte");
    a_log_code: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R9]
        log_go |=> tx_code == CMD_LOG && log_ack_o)
        else $error("log frame has wrong code");
    a_echo_len: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R10]
        state == S_EXEC && !cmd_bad && is_echo |=> tx_echo && tx_len == $past(rx_len))
        else $error("echo length differs");
    a_reset_pulse: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R11]
        state == S_EXEC && !cmd_bad && cmd == CMD_RESET |=> job_o.soft_reset ##1 !job_o.soft_reset)
        else $error("soft reset not one pulse");
    a_auto_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R18]
        state == S_EXEC && !cmd_bad && cmd == CMD_MEAS_GO |=> meas_auto_o)
        else $error("auto measurement not started");
    a_auto_stop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R19]
        state == S_EXEC && !cmd_bad && cmd == CMD_MEAS_END |=> !meas_auto_o)
        else $error("auto measurement not stopped");
    a_no_overfill: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        buf_cnt == 2'd2 |-> !fill)
        else $error("skid buffer overfilled");
    a_answer_kept: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R5]
        frame_done |-> state == S_IDLE || state == S_BODY)
        else $error("received command would go unanswered");
    a_get_reply: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R12]
        state == S_EXEC && !cmd_bad && is_get
        |=> tx_code == cmd && tx_len == 7'(1 + REPLY_BYTES))
        else $error("get reply has wrong code or length");
    a_reinit_stop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // [R21]
        state == S_EXEC && !cmd_bad && cmd == CMD_REINIT |=> job_o.reinit && !meas_auto_o)
        else $error("reinit not issued or auto run kept");
    a_tx_held: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data))
        else $error("stalled byte lost or changed");

    c_echo: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state == S_EXEC && is_echo && !cmd_bad);
    c_nak: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state == S_EXEC && cmd_bad);
    c_log: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) log_go);
    c_stall: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        buf_cnt == 2'd2 && !tx_ready_i);

    wire unused_ok = frame_busy_i;
endmodule // tofcs_slave

`default_nettype wire

// [tofcs_host.sv]
// host model: stuffs command frames and collects reply bytes
`timescale 1ns/1ps
`default_nettype none

module tofcs_host
    import tofcs_pkg::*;
(
    // clock
    input  wire logic                   clk_sys_i,
    // stream towards the slave
    output tofcs_pkg::tofcs_byte_t      rx_o,
    input  wire logic                   rx_ready_i,
    // stream from the slave
    input  wire tofcs_pkg::tofcs_byte_t tx_i,
    output logic                        tx_ready_o,
    // back-pressure from the bench
    input  wire logic                   stall_i
);
    logic [7:0] outq[$];
    logic [7:0] inq[$];

    initial rx_o = '0;
    initial tx_ready_o = 1'b0;

    // idle data toggles so a stale byte never looks live
    always @(posedge clk_sys_i) begin
        tx_ready_o <= !stall_i;
        if (tx_i.valid && tx_ready_o) inq.push_back(tx_i.data);
        if (!(rx_o.valid && !rx_ready_i)) begin
            if (outq.size() > 0) rx_o <= {1'b1, outq.pop_front()};
            else rx_o <= {1'b0, ~rx_o.data};
        end
    end

    // ----------------
    // frame tasks
    // ----------------
    task automatic send_frame(input logic [7:0] pl[$]);
        @(negedge clk_sys_i);
        outq.push_back(DEF_START);
        foreach (pl[i]) begin
            if (pl[i] == DEF_START || pl[i] == DEF_STOP || pl[i] == DEF_ESC) begin
                outq.push_back(DEF_ESC);
                outq.push_back(~pl[i]);
            end else outq.push_back(pl[i]);
        end
        outq.push_back(DEF_STOP);
    endtask

    task automatic push_raw(input logic [7:0] b);
        @(negedge clk_sys_i);
        outq.push_back(b);
    endtask

    // bounded wait; a missing frame comes back empty
    task automatic get_frame(output logic [7:0] f[$]);
        logic [7:0] b;
        logic       esc;
        f = {};
        esc = 1'b0;
        for (int n = 0; n < 2000; n++) begin
            @(negedge clk_sys_i);
            while (inq.size() > 0) begin
                b = inq.pop_front();
                if (b == DEF_START) f = {};
                else if (b == DEF_STOP) return;
                else if (b == DEF_ESC) esc = 1'b1;
                else begin
                    f.push_back(esc ? ~b : b);
                    esc = 1'b0;
                end
            end
        end
        f = {};
    endtask
endmodule // tofcs_host

`default_nettype wire

// [tb.sv]
// self-checking bench for the tof serial command slave
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tofcs_pkg::*;
    localparam logic [31:0] SWV  = 32'h1111_2222;
    localparam logic [31:0] CHV  = 32'h0303_4444;
    localparam logic [31:0] MDV  = 32'h5566_7788;
    localparam logic [31:0] UIDV = 32'h021b_0355;  // arbitrary, holds special bytes

    logic        clk_sys_i, nrst_i, tx_ready, rx_ready, log_req, log_ack;
    logic        job_fail, meas_auto, stall;
    logic [7:0]  log_data;
    tofcs_byte_t rx, tx;
    tofcs_job_t  job, job_seen;
    int          miscompares, total_checks;
    logic [7:0]  q[$], e[$], f[$];

    tofcs_slave #(.SW_VER(SWV), .CHIP_VER(CHV), .MOD_VER(MDV), .UID(UIDV)) i_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rx_i(rx), .rx_ready_o(rx_ready),
        .tx_o(tx), .tx_ready_i(tx_ready), .log_req_i(log_req), .log_data_i(log_data),
        .log_ack_o(log_ack), .job_o(job), .job_fail_i(job_fail),
        .meas_auto_o(meas_auto), .frame_busy_i(meas_auto));
    tofcs_host i_host (.clk_sys_i(clk_sys_i), .rx_o(rx), .rx_ready_i(rx_ready),
        .tx_i(tx), .tx_ready_o(tx_ready), .stall_i(stall));

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) job_seen <= job_seen | job;

    // ----------------
    // shared tasks
    // ----------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cmp_frame(input logic [7:0] x[$]);
        i_host.get_frame(f);
        check("reply length", f.size(), x.size());
        foreach (x[i]) check("reply byte", f[i], x[i]);
    endtask

    task automatic exchange(input logic [7:0] c[$], input logic [7:0] x[$]);
        job_seen = '0;
        i_host.send_frame(c);
        cmp_frame(x);
    endtask

    task automatic finish_test();
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic t_control();
        logic [7:0] c[6] = '{CMD_MEAS_ONE, CMD_MEAS_GO, CMD_MEAS_END,
                             CMD_CALIB, CMD_REINIT, CMD_RESET};
        for (int i = 0; i < 6; i++) begin
            q = {c[i]};
            e = {CMD_ACK};
            exchange(q, e);
            check("job", job_seen, 6'h20 >> i);
            check("auto", meas_auto, i == 1);
        end
    endtask

    task automatic t_get();
        logic [7:0]  c[5] = '{CMD_SW_VER, CMD_CHIP_VER, CMD_MODULE, CMD_UID, CMD_INFO};
        logic [31:0] v[5] = '{SWV, CHV, MDV, UIDV, SWV ^ CHV ^ MDV};
        for (int i = 0; i < 5; i++) begin
            q = {c[i]};
            e = {c[i], v[i][31:24], v[i][23:16], v[i][15:8], v[i][7:0]};
            exchange(q, e);
        end
        i_host.push_raw(8'h55);
        i_host.push_raw(DEF_START);
        i_host.push_raw(CMD_SW_VER);
        q = {CMD_UID};
        e = {CMD_UID, UIDV[31:24], UIDV[23:16], UIDV[15:8], UIDV[7:0]};
        exchange(q, e);
    endtask

    task automatic t_nak();
        logic [7:0] c[3] = '{CMD_INVALID, 8'h33, CMD_ACK};
        e = {CMD_NAK};
        foreach (c[i]) begin
            q = {c[i]};
            exchange(q, e);
        end
        q = {};
        exchange(q, e);
        q = {CMD_TEST};
        repeat (64) q.push_back(8'h5a);
        exchange(q, e);
        @(posedge clk_sys_i);
        job_fail <= 1'b1;
        q = {CMD_CALIB};
        exchange(q, e);
        check("failed job", job_seen, 6'h00);
        @(posedge clk_sys_i);
        job_fail <= 1'b0;
    endtask

    task automatic t_echo();
        q = {CMD_TEST, DEF_START, DEF_STOP, DEF_ESC};
        for (int i = 4; i < 64; i++) q.push_back(8'(i * 7));
        @(posedge clk_sys_i);
        stall <= 1'b1;
        i_host.send_frame(q);
        repeat (300) @(posedge clk_sys_i);
        check("held byte", tx.valid, 1'b1);
        check("none taken", i_host.inq.size(), 0);
        stall <= 1'b0;
        cmp_frame(q);
    endtask

    task automatic t_log();
        int n;
        @(posedge clk_sys_i);
        log_data <= DEF_ESC;
        log_req <= 1'b1;
        for (n = 0; n < 100 && log_ack !== 1'b1; n++) @(negedge clk_sys_i);
        check("log ack", log_ack, 1'b1);
        @(posedge clk_sys_i);
        log_req <= 1'b0;
        e = {CMD_LOG, DEF_ESC};
        cmp_frame(e);
    endtask

    // logs keep firing while a command arrives; its reply must still come
    task automatic t_log_busy();
        int k;
        @(posedge clk_sys_i);
        log_data <= 8'h44;
        log_req <= 1'b1;
        q = {CMD_SW_VER};
        i_host.send_frame(q);
        f = {CMD_LOG};
        for (k = 0; k < 40 && f.size() > 0 && f[0] == CMD_LOG; k++) i_host.get_frame(f);
        @(posedge clk_sys_i);
        log_req <= 1'b0;
        check("reply amid logs", f.size() > 0 ? f[0] : 8'h00, CMD_SW_VER);
        repeat (20) @(posedge clk_sys_i);
        i_host.inq.delete();
    endtask

    initial begin
        nrst_i = 1'b0;
        log_req = 1'b0;
        log_data = 8'h00;
        job_fail = 1'b0;
        stall = 1'b0;
        job_seen = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_sys_i);
        check("reset idle", {tx.valid, job, meas_auto, log_ack}, 32'h0);
        nrst_i <= 1'b1;
        t_control();
        t_get();
        t_nak();
        t_echo();
        t_log();
        t_log_busy();
        finish_test();
    end

    // hang guard well beyond the roughly one thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        finish_test();
    end
endmodule // tb

`default_nettype wire
